// ==== pkg/scb_pkg.sv ====
package scb_pkg;
  localparam logic [4:0] ADDR_BAUD_CTRL  = 5'h00;
  localparam logic [4:0] ADDR_BAUD_FRAC  = 5'h04;
  localparam logic [4:0] ADDR_MODE0      = 5'h08;
  localparam logic [4:0] ADDR_CTRL       = 5'h0c;
  localparam logic [4:0] ADDR_MODE2      = 5'h10;
  localparam logic [4:0] ADDR_TMR_CMP    = 5'h14;
  localparam logic [4:0] ADDR_STATUS     = 5'h18;

  localparam int TAP0_BIT = 0;
  localparam int TAP1_BIT = 2;
  localparam int TAP2_BIT = 4;
  localparam int TAP3_BIT = 6;
  localparam int PRE_W    = 7;

  localparam logic [3:0] RX_SAMPLE_A = 4'h7;
  localparam logic [3:0] RX_SAMPLE_B = 4'h8;
  localparam logic [3:0] RX_SAMPLE_C = 4'h9;
  localparam logic [3:0] CNT_LAST    = 4'hf;
  localparam logic [4:0] FRAC_ONE    = 5'h10;

  typedef enum logic [1:0] {
    SCB_UCLK_TIMER = 2'h0,
    SCB_UCLK_BRG   = 2'h1,
    SCB_UCLK_SYS   = 2'h2,
    SCB_UCLK_EXT   = 2'h3
  } scb_uclk_t;

  // bit 0 of mode_reg0 field: 0 io interface, 1 uart
  typedef struct packed {
    logic [1:0] gen_input_clk_sel;
    logic       frac_en;
    logic [3:0] divisor;
    logic [3:0] fraction;
    logic       uart_mode;
    scb_uclk_t  uart_clk_sel;
    logic       clk_in;
    logic       edge_fall;
    logic       buffer_mode;
    logic [15:0] tmr_cmp;
  } scb_cfg_t;

  localparam scb_cfg_t CFG_RESET = '{2'h0, 1'b0, 4'h2, 4'h1, 1'b0,
                                     SCB_UCLK_TIMER, 1'b0, 1'b0, 1'b0,
                                     16'h0001};
endpackage

// ==== logic/scb_top.sv ====
`timescale 1ns/1ps
module scb_top #(
  parameter int BUF_W = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [4:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             sclk_i,
  output logic                  sclk_o,
  output logic                  sclk_oe,
  input  wire logic             rxd_i,
  output logic                  shift_clock,
  output logic                  tx_bit_tick,
  output logic                  rx_double,
  output logic                  tx_double,
  output logic                  rx_bit_valid,
  output logic      [BUF_W-1:0] rx_bit_data,
  input  wire logic             rx_bit_ready
);
  logic              rst_s1_reg;
  logic              rst_n_reg;
  scb_pkg::scb_cfg_t cfg_reg;
  logic              wait_reg;
  logic [31:0]       rdata_reg;
  logic [scb_pkg::PRE_W-1:0] pre_reg;
  logic              tap_tick;
  logic [4:0]        brg_cnt_reg;
  logic [4:0]        brg_len_reg;
  logic [3:0]        frac_acc_reg;
  logic [4:0]        frac_sum;
  logic [4:0]        n_val;
  logic              brg_pulse_reg;
  logic [15:0]       tmr_cnt_reg;
  logic              tff_reg;
  logic              tmr_rise_reg;
  logic              sclk_prev_reg;
  logic              ext_edge;
  logic              tick_next;
  logic              step;
  logic [3:0]        rx_cnt_reg;
  logic [3:0]        tx_cnt_reg;
  logic [2:0]        vote_reg;
  logic              push;
  logic [BUF_W-1:0]  push_data;
  logic              pop;
  logic              tail_v_reg;
  logic [BUF_W-1:0]  tail_d_reg;
  logic              req;

  // reset released through two flops, asserted at once
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // avalon slave: every access answers with waitrequest low one cycle
  // after it is seen, so the master always waits exactly one cycle
  assign req = avs_read | avs_write;

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !(req && wait_reg);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && wait_reg) begin
      case (avs_address)
        scb_pkg::ADDR_BAUD_CTRL: rdata_reg <= {25'h0, cfg_reg.frac_en,
          cfg_reg.gen_input_clk_sel, cfg_reg.divisor};
        scb_pkg::ADDR_BAUD_FRAC: rdata_reg <= {28'h0, cfg_reg.fraction};
        scb_pkg::ADDR_MODE0: rdata_reg <= {28'h0, cfg_reg.uart_clk_sel,
          1'b0, cfg_reg.uart_mode};
        scb_pkg::ADDR_CTRL: rdata_reg <= {30'h0, cfg_reg.edge_fall,
          cfg_reg.clk_in};
        scb_pkg::ADDR_MODE2: rdata_reg <= {31'h0, cfg_reg.buffer_mode};
        scb_pkg::ADDR_TMR_CMP: rdata_reg <= {16'h0, cfg_reg.tmr_cmp};
        scb_pkg::ADDR_STATUS: rdata_reg <= {24'h0, rx_cnt_reg,
          tail_v_reg, rx_bit_valid, tx_double, rx_double};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // a write lands at the edge where waitrequest is seen low
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg_reg <= scb_pkg::CFG_RESET;
    end else if (avs_write && !wait_reg) begin
      case (avs_address)
        scb_pkg::ADDR_BAUD_CTRL: begin
          cfg_reg.divisor           <= avs_writedata[3:0];
          cfg_reg.gen_input_clk_sel <= avs_writedata[5:4];
          cfg_reg.frac_en           <= avs_writedata[6];
        end
        scb_pkg::ADDR_BAUD_FRAC: cfg_reg.fraction <= avs_writedata[3:0];
        scb_pkg::ADDR_MODE0: begin
          cfg_reg.uart_mode    <= avs_writedata[0];
          cfg_reg.uart_clk_sel <= scb_pkg::scb_uclk_t'(avs_writedata[3:2]);
        end
        scb_pkg::ADDR_CTRL: begin
          cfg_reg.clk_in    <= avs_writedata[0];
          cfg_reg.edge_fall <= avs_writedata[1];
        end
        scb_pkg::ADDR_MODE2: cfg_reg.buffer_mode <= avs_writedata[0];
        scb_pkg::ADDR_TMR_CMP: cfg_reg.tmr_cmp <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end

  // free prescaler; a tap fires when its bit and all bits below it are ones
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  always_comb begin
    case (cfg_reg.gen_input_clk_sel)
      2'h0:    tap_tick = &pre_reg[scb_pkg::TAP0_BIT:0];
      2'h1:    tap_tick = &pre_reg[scb_pkg::TAP1_BIT:0];
      2'h2:    tap_tick = &pre_reg[scb_pkg::TAP2_BIT:0];
      default: tap_tick = &pre_reg[scb_pkg::TAP3_BIT:0];
    endcase
  end

  // divisor field 0 reads as 16; fraction adds one tick on carry
  assign n_val    = (cfg_reg.divisor == 4'h0) ? scb_pkg::FRAC_ONE
                                              : {1'b0, cfg_reg.divisor};
  assign frac_sum = {1'b0, frac_acc_reg}
                  + (scb_pkg::FRAC_ONE - {1'b0, cfg_reg.fraction});

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      brg_cnt_reg   <= 5'h01;
      brg_len_reg   <= 5'h02;
      frac_acc_reg  <= 4'h0;
      brg_pulse_reg <= 1'b0;
    end else begin
      brg_pulse_reg <= 1'b0;
      if (tap_tick) begin
        if (brg_cnt_reg >= brg_len_reg) begin
          brg_pulse_reg <= 1'b1;
          brg_cnt_reg   <= 5'h01;
          if (cfg_reg.uart_mode && cfg_reg.frac_en) begin
            frac_acc_reg <= frac_sum[3:0];
            brg_len_reg  <= n_val + {4'h0, frac_sum[4]};
          end else begin
            frac_acc_reg <= 4'h0;
            brg_len_reg  <= n_val;
          end
        end else begin
          brg_cnt_reg <= brg_cnt_reg + 5'h01;
        end
      end
    end
  end

  // timer flip-flop toggles on compare match; a shift period is two
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tmr_cnt_reg  <= 16'h0000;
      tff_reg      <= 1'b0;
      tmr_rise_reg <= 1'b0;
    end else begin
      tmr_rise_reg <= 1'b0;
      if (tmr_cnt_reg >= cfg_reg.tmr_cmp) begin
        tmr_cnt_reg  <= 16'h0000;
        tff_reg      <= !tff_reg;
        tmr_rise_reg <= !tff_reg;
      end else begin
        tmr_cnt_reg <= tmr_cnt_reg + 16'h0001;
      end
    end
  end

  // external clock is synchronous to clk_sys, so one delay finds edges
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_i;
    end
  end

  assign ext_edge = cfg_reg.edge_fall ? (sclk_prev_reg && !sclk_i)
                                      : (!sclk_prev_reg && sclk_i);

  always_comb begin
    if (!cfg_reg.uart_mode) begin
      if (cfg_reg.clk_in) begin
        tick_next = ext_edge;
      end else begin
        tick_next = brg_pulse_reg && !sclk_o;
      end
    end else begin
      case (cfg_reg.uart_clk_sel)
        scb_pkg::SCB_UCLK_TIMER: tick_next = tmr_rise_reg;
        scb_pkg::SCB_UCLK_BRG:   tick_next = brg_pulse_reg;
        scb_pkg::SCB_UCLK_SYS:   tick_next = 1'b1;
        scb_pkg::SCB_UCLK_EXT:   tick_next = !sclk_prev_reg && sclk_i;
        default:                 tick_next = 1'b0;
      endcase
    end
  end

  // divided clock out; idles low while the pin is an input
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sclk_o  <= 1'b0;
      sclk_oe <= 1'b0;
    end else begin
      sclk_oe <= !cfg_reg.uart_mode && !cfg_reg.clk_in;
      if (cfg_reg.uart_mode || cfg_reg.clk_in) begin
        sclk_o <= 1'b0;
      end else if (brg_pulse_reg) begin
        sclk_o <= !sclk_o;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shift_clock <= 1'b0;
    end else begin
      shift_clock <= tick_next;
    end
  end

  // a full buffer drops the tick instead of a decided bit: the counters
  // simply wait, trading bit timing accuracy for no lost data
  assign step = shift_clock && !tail_v_reg;

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rx_cnt_reg  <= 4'h0;
      tx_cnt_reg  <= 4'h0;
      tx_bit_tick <= 1'b0;
      vote_reg    <= 3'h0;
    end else begin
      tx_bit_tick <= 1'b0;
      if (step && cfg_reg.uart_mode) begin
        rx_cnt_reg  <= rx_cnt_reg + 4'h1;
        tx_cnt_reg  <= tx_cnt_reg + 4'h1;
        tx_bit_tick <= (tx_cnt_reg == scb_pkg::CNT_LAST);
        if (rx_cnt_reg + 4'h1 == scb_pkg::RX_SAMPLE_A) begin
          vote_reg[0] <= rxd_i;
        end
        if (rx_cnt_reg + 4'h1 == scb_pkg::RX_SAMPLE_B) begin
          vote_reg[1] <= rxd_i;
        end
      end else if (step) begin
        tx_bit_tick <= 1'b1;
      end
      if (!cfg_reg.uart_mode) begin
        rx_cnt_reg <= 4'h0;
        tx_cnt_reg <= 4'h0;
      end
    end
  end

  // uart decides at the ninth count by majority, io takes each tick
  always_comb begin
    push      = 1'b0;
    push_data = '0;
    if (step && cfg_reg.uart_mode) begin
      push      = (rx_cnt_reg + 4'h1 == scb_pkg::RX_SAMPLE_C);
      push_data = BUF_W'((vote_reg[0] & vote_reg[1])
                | (vote_reg[0] & rxd_i) | (vote_reg[1] & rxd_i));
    end else if (step) begin
      push      = 1'b1;
      push_data = BUF_W'(rxd_i);
    end
  end

  // two-entry buffer: head drives the port, tail absorbs one stall
  assign pop = rx_bit_valid && rx_bit_ready;

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rx_bit_valid <= 1'b0;
      rx_bit_data  <= '0;
      tail_v_reg   <= 1'b0;
      tail_d_reg   <= '0;
    end else if (pop) begin
      if (tail_v_reg) begin
        rx_bit_data <= tail_d_reg;
        tail_v_reg  <= push;
        tail_d_reg  <= push_data;
      end else begin
        rx_bit_valid <= push;
        rx_bit_data  <= push_data;
      end
    end else if (push) begin
      if (!rx_bit_valid) begin
        rx_bit_valid <= 1'b1;
        rx_bit_data  <= push_data;
      end else begin
        tail_v_reg <= 1'b1;
        tail_d_reg <= push_data;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rx_double <= 1'b0;
      tx_double <= 1'b0;
    end else begin
      rx_double <= cfg_reg.uart_mode || cfg_reg.clk_in
                || cfg_reg.buffer_mode;
      tx_double <= cfg_reg.buffer_mode;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n_reg);

  a_tap_div_two: assert property (
    (cfg_reg.gen_input_clk_sel == 2'h0 && tap_tick) ##2
    (cfg_reg.gen_input_clk_sel == 2'h0) |-> tap_tick && !$past(tap_tick))
    else $error("tap by two not every second cycle");
  a_int_div_len: assert property (
    (brg_pulse_reg && !(cfg_reg.uart_mode && cfg_reg.frac_en))
    |-> brg_len_reg == n_val || !$stable(cfg_reg))
    else $error("integer divide length wrong");
  a_frac_carry: assert property (
    (tap_tick && brg_cnt_reg >= brg_len_reg && cfg_reg.uart_mode
     && cfg_reg.frac_en && $stable(cfg_reg))
    |=> brg_len_reg == $past(n_val) + {4'h0, $past(frac_sum[4])})
    else $error("fractional length wrong");
  a_io_clk_half: assert property (
    (brg_pulse_reg && !cfg_reg.uart_mode && !cfg_reg.clk_in)
    |=> sclk_o != $past(sclk_o))
    else $error("io clock not toggled by generator");
  a_io_edge_sel: assert property (
    (!cfg_reg.uart_mode && cfg_reg.clk_in && cfg_reg.edge_fall
     && sclk_prev_reg && !sclk_i) |=> shift_clock)
    else $error("falling edge not taken");
  a_timer_two_toggles: assert property (
    tmr_rise_reg |-> (tff_reg && !$past(tff_reg)) ##1 !tmr_rise_reg)
    else $error("timer tick not on rising toggle");
  a_uart_div16: assert property (
    (tx_bit_tick && cfg_reg.uart_mode && $past(cfg_reg.uart_mode))
    |-> $past(tx_cnt_reg) == scb_pkg::CNT_LAST)
    else $error("bit tick not at count wrap");
  a_rx_buffer_mode: assert property (
    (cfg_reg.uart_mode && $stable(cfg_reg)) |=> rx_double)
    else $error("uart receive not double buffered");
  a_tx_buffer_mode: assert property (
    $stable(cfg_reg.buffer_mode) |=> tx_double == $past(cfg_reg.buffer_mode))
    else $error("transmit buffer mode wrong");
  a_buf_hold: assert property (
    (rx_bit_valid && !rx_bit_ready) |=> rx_bit_valid
    && $stable(rx_bit_data))
    else $error("buffer head dropped under stall");
  a_bus_answer: assert property (
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");

  c_uart_bit: cover property (cfg_reg.uart_mode && tx_bit_tick);
  c_buf_full: cover property (tail_v_reg && !rx_bit_ready);
  c_io_clk_out: cover property (sclk_oe && $rose(sclk_o));
  c_frac_extra: cover property (brg_pulse_reg && brg_len_reg > n_val);
endmodule

// ==== verif/scb_partner.sv ====
`timescale 1ns/1ps
module scb_partner (
  input  wire logic       clk,
  input  wire logic       clk_en,
  input  wire logic [3:0] hi_cyc,
  input  wire logic [3:0] lo_cyc,
  input  wire logic       data_en,
  input  wire logic       data_val,
  output logic            sclk,
  output logic            rxd
);
  logic [3:0] cnt_reg;
  logic [1:0] ph_reg;

  initial begin
    sclk = 1'b0;
    rxd = 1'b0;
    cnt_reg = 4'h1;
    ph_reg = 2'h0;
  end

  // bench only sets phases of at least 2 system clocks each
  always @(posedge clk) begin
    if (!clk_en) begin
      sclk <= 1'b0;
      cnt_reg <= 4'h1;
    end else if (cnt_reg >= (sclk ? hi_cyc : lo_cyc)) begin
      sclk <= !sclk;
      cnt_reg <= 4'h1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // one bad cycle in four: never two of three adjacent samples
  always @(posedge clk) begin
    ph_reg <= ph_reg + 2'h1;
    if (data_en) begin
      rxd <= data_val ^ (ph_reg == 2'h0);
    end else begin
      rxd <= !rxd;
    end
  end
endmodule

// ==== verif/scb_top_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, ac) \
  begin \
    checked++; \
    if ((ac) !== (ex)) begin \
      mismatches++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, ac); \
    end \
  end
module scb_top_tb;
  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        sclk_i, sclk_o, sclk_oe, rxd_i, shift_clock, tx_bit_tick;
  logic        rx_double, tx_double, rx_bit_valid, rx_bit_ready;
  logic [0:0]  rx_bit_data;
  logic        p_clk_en, p_data_en, p_data_val, sclk_prev;
  logic [3:0]  p_hi, p_lo;
  int          mismatches, checked, cyc, seed, g, n, since_rise;
  localparam logic [31:0] RV [7] = '{32'h2, 32'h1, 32'h0, 32'h0, 32'h0,
                                     32'h1, 32'h0};

  scb_top u_scb_top (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .rxd_i(rxd_i),
    .shift_clock(shift_clock), .tx_bit_tick(tx_bit_tick),
    .rx_double(rx_double), .tx_double(tx_double),
    .rx_bit_valid(rx_bit_valid), .rx_bit_data(rx_bit_data),
    .rx_bit_ready(rx_bit_ready));

  scb_partner u_scb_partner (.clk(clk_sys), .clk_en(p_clk_en),
    .hi_cyc(p_hi), .lo_cyc(p_lo), .data_en(p_data_en),
    .data_val(p_data_val), .sclk(sclk_i), .rxd(rxd_i));

  always #2.5 clk_sys = ~clk_sys;

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // budget roughly five to six times the expected run length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sclk_prev <= sclk_i;
    since_rise <= (sclk_i && !sclk_prev) ? 0 : since_rise + 1;
    if (cyc == 40000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // first interval after a change may be stale, so two pulses are skipped
  task automatic gap(input bit tx);
    repeat (2)
      do @(posedge clk_sys);
      while ((tx ? tx_bit_tick : shift_clock) !== 1'b1);
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while ((tx ? tx_bit_tick : shift_clock) !== 1'b1);
  endtask

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {p_clk_en, p_data_en, p_data_val, sclk_prev} = '0;
    rx_bit_ready = 1'b1;
    p_hi = 4'h2;
    p_lo = 4'h2;
    {mismatches, checked, cyc, since_rise} = '0;
    seed = 32'h02388cd2;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b1, 5'h1c, 32'hffffffff);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, (i == 6) ? 5'h1c : 5'(i * 4), 32'h0);
      `CHK("reset value", RV[i], q);
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, scb_pkg::ADDR_MODE0, 32'(8 + i % 2));
      bus(1'b1, scb_pkg::ADDR_CTRL, 32'(i / 2 % 2));
      bus(1'b1, scb_pkg::ADDR_MODE2, 32'(i / 4));
      repeat (2) @(posedge clk_sys);
      `CHK("rx_double", i != 0, rx_double);
      `CHK("tx_double", i >= 4, tx_double);
    end
    bus(1'b1, scb_pkg::ADDR_MODE0, 32'h0);
    bus(1'b1, scb_pkg::ADDR_CTRL, 32'h0);
    for (int s = 0; s < 4; s++) begin
      n = (s == 0) ? 1 : 1 + ({$random(seed)} % 16);
      bus(1'b1, scb_pkg::ADDR_MODE2, 32'(n == 1));
      bus(1'b1, scb_pkg::ADDR_BAUD_CTRL, 32'(s * 16 + n % 16));
      gap(1'b0);
      `CHK("io period", (4 << (2 * s)) * n, g);
      `CHK("clock drive", 1'b1, sclk_oe);
      `CHK("clock out", 1'b1, sclk_o);
    end
    bus(1'b1, scb_pkg::ADDR_MODE2, 32'h0);
    bus(1'b1, scb_pkg::ADDR_MODE0, 32'h5);
    bus(1'b1, scb_pkg::ADDR_BAUD_CTRL, 32'h15);
    gap(1'b1);
    `CHK("uart bit", 640, g);
    n = 1 + ({$random(seed)} % 15);
    bus(1'b1, scb_pkg::ADDR_BAUD_FRAC, 32'(n));
    bus(1'b1, scb_pkg::ADDR_BAUD_CTRL, 32'h43);
    gap(1'b1);
    `CHK("frac bit", 96 + 2 * (16 - n), g);
    gap(1'b0);
    `CHK("frac step", 1'b1, g == 6 || g == 8);
    bus(1'b1, scb_pkg::ADDR_MODE0, 32'h9);
    gap(1'b0);
    `CHK("sys step", 1, g);
    gap(1'b1);
    `CHK("sys bit", 16, g);
    n = 1 + ({$random(seed)} % 8);
    bus(1'b1, scb_pkg::ADDR_TMR_CMP, 32'(n));
    bus(1'b1, scb_pkg::ADDR_MODE0, 32'h1);
    gap(1'b0);
    `CHK("timer step", 2 * (n + 1), g);
    p_clk_en <= 1'b1;
    bus(1'b1, scb_pkg::ADDR_MODE0, 32'hd);
    gap(1'b0);
    `CHK("ext step", 4, g);
    p_hi <= 4'h4;
    p_lo <= 4'h5;
    for (int f = 0; f < 2; f++) begin
      bus(1'b1, scb_pkg::ADDR_MODE0, 32'h0);
      bus(1'b1, scb_pkg::ADDR_CTRL, 32'(1 + 2 * f));
      gap(1'b0);
      `CHK("in step", 9, g);
      `CHK("edge", 1'(f), since_rise >= 4);
      `CHK("clock drive", 1'b0, sclk_oe);
      `CHK("clock idle", 1'b0, sclk_o);
    end
    p_clk_en <= 1'b0;
    bus(1'b1, scb_pkg::ADDR_MODE0, 32'h9);
    for (int v = 0; v < 2; v++) begin
      p_data_val <= 1'(v);
      p_data_en <= 1'b1;
      repeat (40) @(posedge clk_sys);
      repeat (100) begin
        @(posedge clk_sys);
        if (rx_bit_valid === 1'b1 && rx_bit_ready === 1'b1)
          `CHK("rx bit", 1'(v), rx_bit_data[0]);
        rx_bit_ready <= 1'($random(seed));
      end
      rx_bit_ready <= 1'b0;
      repeat (80) @(posedge clk_sys);
      bus(1'b0, scb_pkg::ADDR_STATUS, 32'h0);
      `CHK("buffer full", 1'b1, q[3]);
      @(posedge clk_sys);
      rx_bit_ready <= 1'b1;
      repeat (2) begin
        @(posedge clk_sys);
        `CHK("held valid", 1'b1, rx_bit_valid);
        `CHK("held bit", 1'(v), rx_bit_data[0]);
      end
      @(posedge clk_sys);
      `CHK("drained", 1'b0, rx_bit_valid);
    end
    p_data_en <= 1'b0;
    test_done();
  end
endmodule
